// ===== pin_change_pkg.sv
// Package holding register offsets, field positions and reset values of the pin change detector.
package pin_change_pkg;

    localparam int unsigned ADDR_W = 12;

    localparam logic [11:0] OFF_PORTA_RISE   = 12'h000;
    localparam logic [11:0] OFF_PORTA_FALL   = 12'h004;
    localparam logic [11:0] OFF_PORTA_FLAGS  = 12'h008;
    localparam logic [11:0] OFF_PORTB_RISE   = 12'h00c;
    localparam logic [11:0] OFF_PORTB_FALL   = 12'h010;
    localparam logic [11:0] OFF_PORTB_FLAGS  = 12'h014;
    localparam logic [11:0] OFF_PORTC_RISE   = 12'h018;
    localparam logic [11:0] OFF_PORTC_FALL   = 12'h01c;
    localparam logic [11:0] OFF_PORTC_FLAGS  = 12'h020;
    localparam logic [11:0] OFF_IRQ_CTRL     = 12'h024;
    localparam logic [11:0] OFF_IRQ_STATUS   = 12'h028;
    localparam logic [11:0] OFF_IRQ_MASK     = 12'h02c;

    localparam logic [7:0] PORTA_IMPL_MASK   = 8'h3f;
    localparam logic [7:0] PORTB_IMPL_MASK   = 8'hf0;
    localparam logic [7:0] PORTC_IMPL_LARGE  = 8'hff;
    localparam logic [7:0] PORTC_IMPL_SMALL  = 8'h3f;

    localparam int unsigned IRQ_ENABLE_BIT   = 0;
    localparam int unsigned EVT_SUMMARY_BIT  = 0;
    localparam int unsigned EVT_W            = 1;

    localparam logic [7:0] REG_RESET         = 8'h00;

endpackage

// ===== pin_edge_if.sv
// Interface carrying the rise and fall edge pulses between detector and register block.
`timescale 1ns/1ps
`default_nettype none
interface pin_edge_if #(parameter int unsigned W = 24);
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    modport source (output rise, output fall);
    modport sink   (input  rise, input  fall);
endinterface
`default_nettype wire

// ===== pin_edge_detect.sv
// Pin synchroniser and edge detector producing one-cycle rise and fall pulses.
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect #(
    parameter int unsigned W = 24
) (
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic [W-1:0] pins_i,
    pin_edge_if.source     edges
);
    logic [W-1:0] sync_a;
    logic [W-1:0] sync_b;
    logic [W-1:0] prev;
    logic         primed;
    logic [1:0]   warm;

    // Two flip-flops before any logic looks at the pins.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= pins_i;
            sync_b <= sync_a;
        end
    end

    // Prime after reset so the first sample is not taken as an edge.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev <= '0;
            warm <= 2'h0;
        end
        else
        begin
            prev <= sync_b;
            if (warm != 2'h3)
            begin
                warm <= warm + 2'h1;
            end
        end
    end

    // Edges count only once prev holds a real pin sample, three edges after reset.
    assign primed = (warm == 2'h3);

    assign edges.rise = primed ? (sync_b & ~prev) : '0;
    assign edges.fall = primed ? (~sync_b & prev) : '0;

    a_single_edge : assert property (@(posedge clk_i) disable iff (rst_i)
        (edges.rise[0] |=> !edges.rise[0])) else $error("Edge pulse lasted more than one cycle.");
endmodule
`default_nettype wire

// ===== pin_change_detector.sv
// Pin change detector: edge enables, sticky change flags, summary interrupt, APB slave.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Port B pins 7..4 have falling-edge enables setting the pin and summary flags.
// - Port B flag sets on enabled rising or enabled falling edge of its pin.
// - Port B fall-enable and flag bits 3..0 are unimplemented and read zero.
// - Eight port C rising-edge enables set pin flag and summary flag.
// - Eight port C falling-edge enables set pin flag and summary flag.
// - Port C flag sets on enabled rising or enabled falling edge of its pin.
// - Software clears a flag by writing zero; flags hold one until cleared.
// - A zero enable bit stops that edge polarity from setting the flag.
// - Every implemented enable and flag bit resets to zero on any reset.
// - Detection continues with interrupt enable clear; request raised only when enabled.
// - Summary flag is the OR of every individual pin flag.
// - An edge in the same cycle as a flag write leaves the flag set.
module pin_change_detector
    import pin_change_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pin_change_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [7:0]                 porta_pin_i,
    input  wire logic [7:0]                 portb_pin_i,
    input  wire logic [7:0]                 portc_pin_i,
    output logic                            change_irq_summary_o,
    output logic                            irq_o
);
    import pin_change_pkg::*;

    localparam logic [7:0] B_IMPL = LARGE_VARIANT ? PORTB_IMPL_MASK : 8'h00;
    localparam logic [7:0] C_IMPL = LARGE_VARIANT ? PORTC_IMPL_LARGE : PORTC_IMPL_SMALL;

    logic [7:0] porta_rise_enable;
    logic [7:0] porta_fall_enable;
    logic [7:0] porta_change_flags;
    logic [7:0] portb_rise_enable;
    logic [7:0] portb_fall_enable;
    logic [7:0] portb_change_flags;
    logic [7:0] portc_rise_enable;
    logic [7:0] portc_fall_enable;
    logic [7:0] portc_change_flags;
    logic       change_irq_enable;
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_mask;
    logic       summary_prev;
    logic       wr_en;
    logic       rd_en;
    logic       addr_ok;
    logic [7:0] wbyte;
    logic [7:0] a_hit;
    logic [7:0] b_hit;
    logic [7:0] c_hit;

    pin_edge_if #(.W(24)) edges ();

    pin_edge_detect #(.W(24)) u_detect (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pins_i ({portc_pin_i, portb_pin_i, porta_pin_i}),
        .edges  (edges)
    );

    // Enabled-edge hits per port; a zero enable masks that polarity.
    function automatic logic [7:0] hit(input logic [7:0] rise, input logic [7:0] fall,
                                       input logic [7:0] ren, input logic [7:0] fen,
                                       input logic [7:0] impl);
        hit = ((rise & ren) | (fall & fen)) & impl;
    endfunction

    // Flag update: written zero clears, a same-cycle hit wins over the clear.
    function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] h,
                                             input logic we, input logic [7:0] wd,
                                             input logic [7:0] impl);
        flag_next = ((we ? (cur & wd) : cur) | h) & impl;
    endfunction

    assign a_hit = hit(edges.rise[7:0], edges.fall[7:0], porta_rise_enable, porta_fall_enable,
                       PORTA_IMPL_MASK);
    assign b_hit = hit(edges.rise[15:8], edges.fall[15:8], portb_rise_enable, portb_fall_enable,
                       B_IMPL);
    assign c_hit = hit(edges.rise[23:16], edges.fall[23:16], portc_rise_enable, portc_fall_enable,
                       C_IMPL);

    // APB: zero-wait slave; unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite && pstrb[0];
    assign rd_en  = psel && !pwrite;
    assign wbyte  = pwdata[7:0];

    always_comb
    begin
        case (paddr)
            OFF_PORTA_RISE, OFF_PORTA_FALL, OFF_PORTA_FLAGS,
            OFF_PORTB_RISE, OFF_PORTB_FALL, OFF_PORTB_FLAGS,
            OFF_PORTC_RISE, OFF_PORTC_FALL, OFF_PORTC_FLAGS,
            OFF_IRQ_CTRL, OFF_IRQ_STATUS, OFF_IRQ_MASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addr_ok;

    // Enable registers.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            porta_rise_enable <= REG_RESET;
            porta_fall_enable <= REG_RESET;
            portb_rise_enable <= REG_RESET;
            portb_fall_enable <= REG_RESET;
            portc_rise_enable <= REG_RESET;
            portc_fall_enable <= REG_RESET;
            change_irq_enable <= 1'b0;
            irq_mask          <= '0;
        end
        else if (wr_en)
        begin
            case (paddr)
                OFF_PORTA_RISE: porta_rise_enable <= wbyte & PORTA_IMPL_MASK;
                OFF_PORTA_FALL: porta_fall_enable <= wbyte & PORTA_IMPL_MASK;
                OFF_PORTB_RISE: portb_rise_enable <= wbyte & B_IMPL;
                OFF_PORTB_FALL: portb_fall_enable <= wbyte & B_IMPL;
                OFF_PORTC_RISE: portc_rise_enable <= wbyte & C_IMPL;
                OFF_PORTC_FALL: portc_fall_enable <= wbyte & C_IMPL;
                OFF_IRQ_CTRL:   change_irq_enable <= wbyte[IRQ_ENABLE_BIT];
                OFF_IRQ_MASK:   irq_mask <= wbyte[EVT_W-1:0];
                default:        ;
            endcase
        end
    end

    // Sticky change flags.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            porta_change_flags <= REG_RESET;
            portb_change_flags <= REG_RESET;
            portc_change_flags <= REG_RESET;
        end
        else
        begin
            porta_change_flags <= flag_next(porta_change_flags, a_hit, wr_en && paddr == OFF_PORTA_FLAGS,
                                            wbyte, PORTA_IMPL_MASK);
            portb_change_flags <= flag_next(portb_change_flags, b_hit, wr_en && paddr == OFF_PORTB_FLAGS,
                                            wbyte, B_IMPL);
            portc_change_flags <= flag_next(portc_change_flags, c_hit, wr_en && paddr == OFF_PORTC_FLAGS,
                                            wbyte, C_IMPL);
        end
    end

    // Summary flag follows the flag registers; enable gates only the request.
    assign change_irq_summary_o = |{porta_change_flags, portb_change_flags, portc_change_flags};

    // Sticky status: set on the summary rising, cleared by writing one; set wins.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            summary_prev <= 1'b0;
            irq_status   <= '0;
        end
        else
        begin
            summary_prev <= change_irq_summary_o;
            if (wr_en && paddr == OFF_IRQ_STATUS)
            begin
                irq_status <= (irq_status & ~wbyte[EVT_W-1:0]) |
                              {{(EVT_W-1){1'b0}}, change_irq_summary_o & ~summary_prev};
            end
            else
            begin
                irq_status <= irq_status | {{(EVT_W-1){1'b0}}, change_irq_summary_o & ~summary_prev};
            end
        end
    end

    assign irq_o = change_irq_enable && (change_irq_summary_o || |(irq_status & irq_mask));

    // Read data register; reserved bits read zero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prdata <= '0;
        end
        else if (rd_en && !penable)
        begin
            case (paddr)
                OFF_PORTA_RISE:  prdata <= {24'h000000, porta_rise_enable};
                OFF_PORTA_FALL:  prdata <= {24'h000000, porta_fall_enable};
                OFF_PORTA_FLAGS: prdata <= {24'h000000, porta_change_flags};
                OFF_PORTB_RISE:  prdata <= {24'h000000, portb_rise_enable};
                OFF_PORTB_FALL:  prdata <= {24'h000000, portb_fall_enable};
                OFF_PORTB_FLAGS: prdata <= {24'h000000, portb_change_flags};
                OFF_PORTC_RISE:  prdata <= {24'h000000, portc_rise_enable};
                OFF_PORTC_FALL:  prdata <= {24'h000000, portc_fall_enable};
                OFF_PORTC_FLAGS: prdata <= {24'h000000, portc_change_flags};
                OFF_IRQ_CTRL:    prdata <= {31'h00000000, change_irq_enable};
                OFF_IRQ_STATUS:  prdata <= {{(32-EVT_W){1'b0}}, irq_status};
                OFF_IRQ_MASK:    prdata <= {{(32-EVT_W){1'b0}}, irq_mask};
                default:         prdata <= '0;
            endcase
        end
    end

    sequence s_c_rise0;
        edges.rise[16] && portc_rise_enable[0];
    endsequence

    a_c_rise_sets : assert property (@(posedge clk_i) disable iff (rst_i)
        s_c_rise0 |=> portc_change_flags[0]) else $error("Enabled rising edge did not set flag.");
    a_c_fall_sets : assert property (@(posedge clk_i) disable iff (rst_i)
        edges.fall[16] && portc_fall_enable[0] |=> portc_change_flags[0]) else $error("Fall flag missing.");
    a_b_fall_sets : assert property (@(posedge clk_i) disable iff (rst_i)
        edges.fall[12] && portb_fall_enable[4] |=> portb_change_flags[4]) else $error("Port B fall lost.");
    a_b_low_zero : assert property (@(posedge clk_i) disable iff (rst_i)
        portb_change_flags[3:0] == 4'h0 && portb_fall_enable[3:0] == 4'h0) else $error("Port B low bits set.");
    a_flag_holds : assert property (@(posedge clk_i) disable iff (rst_i)
        portc_change_flags[0] && !(wr_en && paddr == OFF_PORTC_FLAGS) |=> portc_change_flags[0])
        else $error("Flag dropped without a clear.");
    a_disabled_edge : assert property (@(posedge clk_i) disable iff (rst_i)
        !portc_change_flags[1] && !(portc_rise_enable[1] && edges.rise[17]) && !(portc_fall_enable[1] && edges.fall[17])
        |=> !portc_change_flags[1]) else $error("Flag set without enabled edge.");
    a_reset_clears : assert property (@(posedge clk_i)
        rst_i |=> portc_change_flags == 8'h00 && portc_rise_enable == 8'h00) else $error("Reset left bits set.");
    a_irq_gate : assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> change_irq_enable) else $error("Interrupt raised while disabled.");
    a_summary_or : assert property (@(posedge clk_i) disable iff (rst_i)
        (portc_change_flags != 8'h00) |-> change_irq_summary_o) else $error("Summary missed a flag.");
    a_edge_wins : assert property (@(posedge clk_i) disable iff (rst_i)
        wr_en && paddr == OFF_PORTC_FLAGS && c_hit != 8'h00 |=> (portc_change_flags & $past(c_hit)) == $past(c_hit))
        else $error("Edge lost during clear.");
    a_small_variant : assert property (@(posedge clk_i) disable iff (rst_i)
        !LARGE_VARIANT |-> portb_change_flags == 8'h00 && portc_change_flags[7:6] == 2'b00)
        else $error("Absent bits set in small variant.");
    a_b_rise_sets : assert property (@(posedge clk_i) disable iff (rst_i)
        edges.rise[15] && portb_rise_enable[7] |=> portb_change_flags[7]) else $error("Port B rise lost.");
endmodule
`default_nettype wire

// ===== port_pin_model.sv
// Model of the external signals on the input pins of ports A, B and C.
`timescale 1ns/1ps
`default_nettype none
module port_pin_model (
    output logic [7:0] porta_o,
    output logic [7:0] portb_o,
    output logic [7:0] portc_o
);
    initial
    begin
        porta_o = 8'h00;
        portb_o = 8'h00;
        portc_o = 8'h00;
    end

    // Pins move only when the bench calls, just after a clock edge, so each change is one clean transition.
    task automatic drive(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        porta_o <= a;
        portb_o <= b;
        portc_o <= c;
    endtask
endmodule
`default_nettype wire

// ===== pin_change_detector_bench.sv
// Self-checking bench for the pin change detector, driving its register bus and pins.
`timescale 1ns/1ps
`default_nettype none
module pin_change_detector_bench;
    import pin_change_pkg::*;
    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'h0;
    logic [3:0]  strb    = 4'hf;
    logic [31:0] prdata;
    logic [31:0] prdata_s;
    logic [31:0] rd_s;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pa;
    logic [7:0]  pb;
    logic [7:0]  pc;
    logic        summary;
    logic        irq;
    logic [31:0] rd;
    logic        err_seen;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [11:0] offs [12] = '{OFF_PORTA_RISE, OFF_PORTA_FALL, OFF_PORTA_FLAGS, OFF_PORTB_RISE, OFF_PORTB_FALL,
        OFF_PORTB_FLAGS, OFF_PORTC_RISE, OFF_PORTC_FALL, OFF_PORTC_FLAGS, OFF_IRQ_CTRL, OFF_IRQ_STATUS, OFF_IRQ_MASK};
    logic [11:0] ens [6] = '{OFF_PORTA_RISE, OFF_PORTA_FALL, OFF_PORTB_RISE, OFF_PORTB_FALL, OFF_PORTC_RISE,
        OFF_PORTC_FALL};
    logic [31:0] ens_exp [6] = '{32'h3f, 32'h3f, 32'hf0, 32'hf0, 32'hff, 32'hff};
    logic [31:0] ens_small [6] = '{32'h3f, 32'h3f, 32'h00, 32'h00, 32'h3f, 32'h3f};

    always #20 clk_i = ~clk_i;

    port_pin_model pm_u (.porta_o(pa), .portb_o(pb), .portc_o(pc));

    pin_change_detector dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .porta_pin_i(pa), .portb_pin_i(pb), .portc_pin_i(pc), .change_irq_summary_o(summary), .irq_o(irq)
    );

    // Smaller variant on the same bus and pins, so the absent bits are seen to read zero.
    pin_change_detector #(.LARGE_VARIANT(1'b0)) dut_small_u (
        .clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_s), .pready(), .pslverr(),
        .porta_pin_i(pa), .portb_pin_i(pb), .portc_pin_i(pc), .change_irq_summary_o(), .irq_o()
    );

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus transfer; the request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= strb;
        @(posedge clk_i);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_i);
        end
        while (pready !== 1'b1);
        rd       = prdata;
        rd_s     = prdata_s;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic do_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            stop_test();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        foreach (offs[i]) rdchk(offs[i], 32'h0);
        $display("test reset_values done");
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, ens[i], 32'hff);
            rdchk(ens[i], ens_exp[i]);
            check(rd_s, ens_small[i]);
        end
        strb = 4'h0;
        apb(1'b1, OFF_PORTC_RISE, 32'h00);
        strb = 4'hf;
        rdchk(OFF_PORTC_RISE, 32'hff);
        apb(1'b0, 12'h030, 32'h0);
        check({31'h0, err_seen}, 32'h1);
        check(rd, 32'h0);
        $display("test enable_access done");
        apb(1'b1, OFF_PORTA_RISE, 32'h00);
        apb(1'b1, OFF_PORTA_FALL, 32'h00);
        apb(1'b1, OFF_PORTB_RISE, 32'h80);
        apb(1'b1, OFF_PORTC_RISE, 32'h0f);
        apb(1'b1, OFF_PORTC_FALL, 32'hf0);
        @(posedge clk_i);
        pm_u.drive(8'hff, 8'hff, 8'hff);
        repeat (5) @(posedge clk_i);
        rdchk(OFF_PORTC_FLAGS, 32'h0f);
        rdchk(OFF_PORTB_FLAGS, 32'h80);
        rdchk(OFF_PORTA_FLAGS, 32'h00);
        check({31'h0, summary}, 32'h1);
        check({31'h0, irq}, 32'h0);
        @(posedge clk_i);
        pm_u.drive(8'h00, 8'h00, 8'h00);
        repeat (5) @(posedge clk_i);
        rdchk(OFF_PORTC_FLAGS, 32'hff);
        rdchk(OFF_PORTB_FLAGS, 32'hf0);
        $display("test edge_detect done");
        apb(1'b1, OFF_PORTB_FLAGS, 32'hff);
        rdchk(OFF_PORTB_FLAGS, 32'hf0);
        apb(1'b1, OFF_PORTC_FLAGS, 32'hf0);
        rdchk(OFF_PORTC_FLAGS, 32'hf0);
        check({31'h0, summary}, 32'h1);
        apb(1'b1, OFF_PORTB_FLAGS, 32'h00);
        apb(1'b1, OFF_PORTC_FLAGS, 32'h00);
        repeat (4) @(posedge clk_i);
        check({31'h0, summary}, 32'h0);
        rdchk(OFF_PORTC_FLAGS, 32'h00);
        $display("test flag_clear done");
        rdchk(OFF_IRQ_STATUS, 32'h1);
        apb(1'b1, OFF_IRQ_MASK, 32'h1);
        apb(1'b1, OFF_IRQ_CTRL, 32'h1);
        @(negedge clk_i);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, OFF_IRQ_STATUS, 32'h1);
        rdchk(OFF_IRQ_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        @(posedge clk_i);
        pm_u.drive(8'h00, 8'h00, 8'h01);
        repeat (5) @(posedge clk_i);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, OFF_IRQ_CTRL, 32'h0);
        @(negedge clk_i);
        check({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        // The rising edge on pin 1 lands on the same edge as the clearing write.
        @(posedge clk_i);
        pm_u.drive(8'h00, 8'h00, 8'h03);
        apb(1'b1, OFF_PORTC_FLAGS, 32'h00);
        rdchk(OFF_PORTC_FLAGS, 32'h02);
        $display("test clear_race done");
        do_reset();
        foreach (offs[i]) rdchk(offs[i], 32'h0);
        check({31'h0, summary}, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test second_reset done");
        stop_test();
    end
endmodule
`default_nettype wire
